// file: tmr2_regs.sv
// Timer 2 reload/capture registers with 16-bit and split 8-bit counting.
// Assumes an SFR byte port on the system clock; clock selects come from outside.
// Function
// (R1) External select 1 picks external oscillator divided by 8 as external tick.
// (R2) The divided external tick is synchronised before it advances any byte.
// (R3) Reload low byte supplies low reload value and is writable at 0xCA.
// (R4) Capture copies counter low byte into reload low byte for reading.
// (R5) In 16-bit mode high byte counts on carry from the low byte.
// (R6) In split mode high byte is an independent 8-bit timer.
// (R7) In split mode run control gates high byte only; low always counts.
// (R8) Byte clock select 1 uses system clock, else div 12 or external div 8.
// (R9) Overflow flags set when high or low byte counts on from FF, whether it wraps to 00 or reloads.
// (R10) Hardware never clears overflow flags; software clears them by writing.
// (R11) Each capture event becomes a one-cycle pulse latching both bytes together.
`timescale 1ns/1ps
module tmr2_regs (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic high_byte_clock_select_in,
  input wire logic low_byte_clock_select_in,
  input wire logic ext_osc_in,
  input wire logic sof_event_in,
  input wire logic lfo_clk_in,
  output logic [7:0] timer_control_out,
  output logic irq_out
);
  import tmr2_pkg::*;
  // ----------------------------------------
  // Registers and helpers
  // ----------------------------------------
  logic [7:0] ctrl_q, rll_q, rlh_q, cntl_q, cnth_q, rdata_q;
  logic [3:0] div12_q;
  logic tick12, tick_low, tick_high, inc_low, inc_high, ovf_low, ovf_high;
  logic sof1_q, sof2_q, sof3_q, lfo1_q, lfo2_q, lfo3_q, cap_q;
  logic cap_evt;
  logic wr_ctrl, wr_rll, wr_rlh, wr_cntl, wr_cnth;
  tmr2_sync_if ext_if ();

  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] b, input logic w);
    wr_hit = w && (a == b);
  endfunction : wr_hit

  tmr2_ext_tick u_ext (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .ext_osc_in(ext_osc_in),
    .sync_out(ext_if.src)
  );

  assign wr_ctrl = wr_hit(sfr_addr_in, TMR2_ADDR_CTRL, sfr_wr_in);
  assign wr_rll = wr_hit(sfr_addr_in, TMR2_ADDR_RLL, sfr_wr_in);
  assign wr_rlh = wr_hit(sfr_addr_in, TMR2_ADDR_RLH, sfr_wr_in);
  assign wr_cntl = wr_hit(sfr_addr_in, TMR2_ADDR_CNTL, sfr_wr_in);
  assign wr_cnth = wr_hit(sfr_addr_in, TMR2_ADDR_CNTH, sfr_wr_in);

  // ----------------------------------------
  // Tick selection
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div12_q <= 4'h0;
    end else if (div12_q == TMR2_DIV12_LAST) begin
      div12_q <= 4'h0;
    end else begin
      div12_q <= div12_q + 4'h1;
    end
  end
  assign tick12 = (div12_q == TMR2_DIV12_LAST);

  function automatic logic pick_tick(input logic sel, input logic xclk, input logic t12,
                                     input logic text);
    if (sel) begin
      pick_tick = 1'b1;
    end else if (xclk) begin
      pick_tick = text;
    end else begin
      pick_tick = t12;
    end
  endfunction : pick_tick

  assign tick_low = pick_tick(low_byte_clock_select_in, ctrl_q[TMR2_B_XCLK], tick12,
                              ext_if.tick); // [R8] [R1]
  assign tick_high = pick_tick(high_byte_clock_select_in, ctrl_q[TMR2_B_XCLK], tick12,
                               ext_if.tick); // [R8]
  // Split mode: low byte free-running, run control only for high byte
  assign inc_low = ctrl_q[TMR2_B_SPLIT] ? tick_low : (ctrl_q[TMR2_B_RUN] && tick_low); // [R7]
  assign inc_high = ctrl_q[TMR2_B_SPLIT] ? (ctrl_q[TMR2_B_RUN] && tick_high) :
                    (inc_low && cntl_q == TMR2_BYTE_MAX); // [R5] [R6]
  assign ovf_low = inc_low && (cntl_q == TMR2_BYTE_MAX); // [R9]
  assign ovf_high = inc_high && (cnth_q == TMR2_BYTE_MAX); // [R9]

  // ----------------------------------------
  // Capture event
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sof1_q <= 1'b0;
      sof2_q <= 1'b0;
      sof3_q <= 1'b0;
      lfo1_q <= 1'b0;
      lfo2_q <= 1'b0;
      lfo3_q <= 1'b0;
    end else begin
      sof1_q <= sof_event_in;
      sof2_q <= sof1_q;
      sof3_q <= sof2_q;
      lfo1_q <= lfo_clk_in;
      lfo2_q <= lfo1_q;
      lfo3_q <= lfo2_q;
    end
  end
  // SOF rising edge or LFO falling edge, one cycle long
  assign cap_evt = ctrl_q[TMR2_B_CSS] ? (lfo3_q && !lfo2_q) : (sof2_q && !sof3_q); // [R11]
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cap_q <= 1'b0;
    end else begin
      cap_q <= cap_evt && ctrl_q[TMR2_B_CE]; // [R11]
    end
  end

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cntl_q <= TMR2_RST_BYTE;
    end else if (wr_cntl) begin
      cntl_q <= sfr_wdata_in;
    end else if (ovf_low && !ctrl_q[TMR2_B_CE] &&
                 (ctrl_q[TMR2_B_SPLIT] || cnth_q == TMR2_BYTE_MAX)) begin
      cntl_q <= rll_q; // [R3]
    end else if (inc_low) begin
      cntl_q <= cntl_q + 8'h01;
    end
  end
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnth_q <= TMR2_RST_BYTE;
    end else if (wr_cnth) begin
      cnth_q <= sfr_wdata_in;
    end else if (ovf_high && !ctrl_q[TMR2_B_CE]) begin
      cnth_q <= rlh_q;
    end else if (inc_high) begin
      cnth_q <= cnth_q + 8'h01; // [R5] [R6]
    end
  end

  // ----------------------------------------
  // Reload and capture registers
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rll_q <= TMR2_RST_BYTE;
      rlh_q <= TMR2_RST_BYTE;
    end else if (cap_q) begin
      rll_q <= cntl_q; // [R4] [R11]
      rlh_q <= cnth_q;
    end else begin
      if (wr_rll) begin
        rll_q <= sfr_wdata_in; // [R3]
      end
      if (wr_rlh) begin
        rlh_q <= sfr_wdata_in;
      end
    end
  end

  // ----------------------------------------
  // Control and flags; set wins over a software clear
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_q <= TMR2_RST_BYTE;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= sfr_wdata_in; // [R10]
      end
      if (ovf_high) begin
        ctrl_q[TMR2_B_FH] <= 1'b1; // [R9]
      end
      if (ovf_low) begin
        ctrl_q[TMR2_B_FL] <= 1'b1; // [R9]
      end
    end
  end
  assign timer_control_out = ctrl_q;
  assign irq_out = ctrl_q[TMR2_B_FH] || (ctrl_q[TMR2_B_LEN] && ctrl_q[TMR2_B_FL]);

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_q <= TMR2_RST_BYTE;
    end else if (sfr_rd_in) begin
      if (sfr_addr_in == TMR2_ADDR_CTRL) begin
        rdata_q <= ctrl_q;
      end else if (sfr_addr_in == TMR2_ADDR_RLL) begin
        rdata_q <= rll_q;
      end else if (sfr_addr_in == TMR2_ADDR_RLH) begin
        rdata_q <= rlh_q;
      end else if (sfr_addr_in == TMR2_ADDR_CNTL) begin
        rdata_q <= cntl_q;
      end else if (sfr_addr_in == TMR2_ADDR_CNTH) begin
        rdata_q <= cnth_q;
      end else begin
        rdata_q <= TMR2_RST_BYTE;
      end
    end
  end
  assign sfr_rdata_out = rdata_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_flag_sticky: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R10]
    $fell(ctrl_q[TMR2_B_FH]) |-> $past(wr_ctrl)) else $error("high flag cleared by hw");
  a_low_flag_sticky: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R10]
    $fell(ctrl_q[TMR2_B_FL]) |-> $past(wr_ctrl)) else $error("low flag cleared by hw");
  a_low_ovf_flag: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R9]
    ovf_low |=> ctrl_q[TMR2_B_FL]) else $error("low flag not set");
  a_high_ovf_flag: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R9]
    ovf_high |=> ctrl_q[TMR2_B_FH]) else $error("high flag not set");
  a_capture_low: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R4]
    cap_q |=> rll_q == $past(cntl_q) && rlh_q == $past(cnth_q))
    else $error("capture lost");
  a_reload_write: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R3]
    wr_rll && !cap_q |=> rll_q == $past(sfr_wdata_in)) else $error("reload write lost");
  a_split_low_free: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R7]
    ctrl_q[TMR2_B_SPLIT] && !ctrl_q[TMR2_B_RUN] && tick_low |-> inc_low)
    else $error("split low byte stalled");
  a_split_high_gate: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R6]
    ctrl_q[TMR2_B_SPLIT] && !ctrl_q[TMR2_B_RUN] && !wr_cnth |=> $stable(cnth_q))
    else $error("high byte ran while stopped");
  a_carry_16: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R5]
    !ctrl_q[TMR2_B_SPLIT] && inc_high |-> cntl_q == TMR2_BYTE_MAX)
    else $error("high byte without carry");
  a_system_clock_sel: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R8]
    low_byte_clock_select_in |-> tick_low) else $error("system_clock select lost");
  a_cap_pulse: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R11]
    cap_q |=> !cap_q) else $error("capture pulse too long");
  c_low_ovf: cover property (@(posedge ref_clk_in) ovf_low);
  c_high_ovf: cover property (@(posedge ref_clk_in) ovf_high);
  c_capture: cover property (@(posedge ref_clk_in) cap_q);
  c_ext_tick: cover property (@(posedge ref_clk_in) ext_if.tick && ctrl_q[TMR2_B_XCLK]);
endmodule : tmr2_regs

// file: tmr2_pkg.sv
// Package for the timer reload/capture register block.
// Assumes an SFR-style byte register port clocked by the system clock.
package tmr2_pkg;
  // ----------------------------------------
  // SFR addresses
  // ----------------------------------------
  localparam logic [7:0] TMR2_ADDR_CTRL = 8'hC8;
  localparam logic [7:0] TMR2_ADDR_RLL = 8'hCA;
  localparam logic [7:0] TMR2_ADDR_RLH = 8'hCB;
  localparam logic [7:0] TMR2_ADDR_CNTL = 8'hCC;
  localparam logic [7:0] TMR2_ADDR_CNTH = 8'hCD;
  // ----------------------------------------
  // Control bit positions
  // ----------------------------------------
  localparam int TMR2_B_XCLK = 0;
  localparam int TMR2_B_CSS = 1;
  localparam int TMR2_B_RUN = 2;
  localparam int TMR2_B_SPLIT = 3;
  localparam int TMR2_B_CE = 4;
  localparam int TMR2_B_LEN = 5;
  localparam int TMR2_B_FL = 6;
  localparam int TMR2_B_FH = 7;
  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [7:0] TMR2_RST_BYTE = 8'h00;
  localparam logic [7:0] TMR2_BYTE_MAX = 8'hFF;
  localparam logic [3:0] TMR2_DIV12_LAST = 4'hB;
  localparam logic [2:0] TMR2_DIV8_LAST = 3'h7;
  localparam int TMR2_CLK_HZ = 10000000;
endpackage : tmr2_pkg

// file: tmr2_sync_if.sv
// Interface carrying the synchronised external tick between modules.
// Assumes one system clock domain.
`timescale 1ns/1ps
interface tmr2_sync_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface : tmr2_sync_if

// file: tmr2_ext_tick.sv
// Divides the external oscillator by 8 and brings the tick into the system clock domain.
// Assumes ext_osc_in is asynchronous and slower than half the system clock.
`timescale 1ns/1ps
module tmr2_ext_tick (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic ext_osc_in,
  tmr2_sync_if.src sync_out
);
  import tmr2_pkg::*;
  logic s1_q, s2_q, s3_q;
  logic [2:0] div_q;
  logic tick_q;
  // Two-stage synchroniser before any logic looks at the oscillator
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin // [R2]
    if (sys_rst_in) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= ext_osc_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // Count rising edges; one tick per eight oscillator periods
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin // [R1]
    if (sys_rst_in) begin
      div_q <= 3'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (s2_q && !s3_q) begin
        div_q <= div_q + 3'h1;
        tick_q <= (div_q == TMR2_DIV8_LAST);
      end
    end
  end
  assign sync_out.tick = tick_q;
  a_div8_tick: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R1]
    tick_q |-> $past(div_q) == TMR2_DIV8_LAST) else $error("tick not on eighth edge");
  a_tick_pulse: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R2]
    tick_q |=> !tick_q) else $error("tick longer than one cycle");
endmodule : tmr2_ext_tick

// file: timer2_reload_capture_regs_bench.sv
// Self-checking bench for the timer reload/capture register block.
// Assumes the block's byte register port and the package constants.
`timescale 1ns/1ps
module timer2_reload_capture_regs_bench;
  import tmr2_pkg::*;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic hcs = 1'b0;
  logic lcs = 1'b0;
  logic osc = 1'b0;
  logic osc_en = 1'b0;
  logic sof = 1'b0;
  logic lfo = 1'b1;
  logic [7:0] rdata;
  logic [7:0] ctrl_out;
  logic irq;
  logic [7:0] v;
  logic [7:0] addr_list [6];
  int osc_cnt = 0;
  int errors = 0;
  int check_count = 0;

  always #50 ref_clk_in = ~ref_clk_in;

  tmr2_regs dut_u (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .sfr_addr_in(addr),
    .sfr_wdata_in(wdata), .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_rdata_out(rdata),
    .high_byte_clock_select_in(hcs), .low_byte_clock_select_in(lcs),
    .ext_osc_in(osc), .sof_event_in(sof), .lfo_clk_in(lfo),
    .timer_control_out(ctrl_out), .irq_out(irq)
  );

  // ----------------------------------------
  // External oscillator at one tenth of the system clock
  // ----------------------------------------
  always @(posedge ref_clk_in) begin
    if (osc_en && osc_cnt == 4) begin
      osc <= ~osc;
      osc_cnt <= 0;
    end else if (osc_en) begin
      osc_cnt <= osc_cnt + 1;
    end
  end

  // ----------------------------------------
  // Register access and comparison tasks
  // ----------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_in);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_in);
    rd <= 1'b0;
    @(posedge ref_clk_in);
    d = rdata;
  endtask : rd_reg

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    check_count++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      errors++;
      $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask : chk_rng

  task automatic report_and_stop();
    if (errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (100000) @(posedge ref_clk_in);
    errors++;
    report_and_stop();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    addr_list = '{TMR2_ADDR_CTRL, TMR2_ADDR_RLL, TMR2_ADDR_RLH, TMR2_ADDR_CNTL,
                  TMR2_ADDR_CNTH, 8'h00};
    repeat (2) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd_reg(addr_list[i], v);
      chk(v, TMR2_RST_BYTE);
    end
    chk(ctrl_out, 8'h00);
    wr_reg(TMR2_ADDR_RLL, 8'hA5);
    rd_reg(TMR2_ADDR_RLL, v);
    chk(v, 8'hA5);
    wr_reg(8'h00, 8'h5A);
    rd_reg(8'h00, v);
    chk(v, 8'h00);
    @(posedge ref_clk_in);
    lcs <= 1'b1;
    hcs <= 1'b1;
    // Split mode with run off: low counts, high holds
    wr_reg(TMR2_ADDR_CNTH, 8'h55);
    wr_reg(TMR2_ADDR_CNTL, 8'h00);
    wr_reg(TMR2_ADDR_CTRL, 8'h08);
    repeat (20) @(posedge ref_clk_in);
    wr_reg(TMR2_ADDR_CTRL, 8'h00);
    rd_reg(TMR2_ADDR_CNTH, v);
    chk(v, 8'h55);
    rd_reg(TMR2_ADDR_CNTL, v);
    chk_rng(v, 8'h14, 8'h1C);
    // Low byte overflow, reload, sticky flag
    wr_reg(TMR2_ADDR_RLL, 8'h80);
    wr_reg(TMR2_ADDR_CNTL, 8'hF0);
    wr_reg(TMR2_ADDR_CTRL, 8'h28);
    repeat (30) @(posedge ref_clk_in);
    rd_reg(TMR2_ADDR_CTRL, v);
    chk(v, 8'h68);
    wr_reg(TMR2_ADDR_CTRL, 8'h60);
    rd_reg(TMR2_ADDR_CTRL, v);
    chk(v, 8'h60);
    chk({7'h00, irq}, 8'h01);
    rd_reg(TMR2_ADDR_CNTL, v);
    chk_rng(v, 8'h88, 8'h98);
    repeat (50) @(posedge ref_clk_in);
    chk(ctrl_out, 8'h60);
    wr_reg(TMR2_ADDR_CTRL, 8'h00);
    rd_reg(TMR2_ADDR_CTRL, v);
    chk(v, 8'h00);
    chk({7'h00, irq}, 8'h00);
    // High byte overflow in split mode with run on
    wr_reg(TMR2_ADDR_CNTH, 8'hF8);
    wr_reg(TMR2_ADDR_CTRL, 8'h0C);
    repeat (20) @(posedge ref_clk_in);
    rd_reg(TMR2_ADDR_CTRL, v);
    chk(v, 8'h8C);
    wr_reg(TMR2_ADDR_CTRL, 8'h80);
    rd_reg(TMR2_ADDR_CTRL, v);
    chk(v, 8'h80);
    chk({7'h00, irq}, 8'h01);
    // 16-bit carry into the high byte
    wr_reg(TMR2_ADDR_CTRL, 8'h00);
    wr_reg(TMR2_ADDR_CNTH, 8'h12);
    wr_reg(TMR2_ADDR_CNTL, 8'hF0);
    wr_reg(TMR2_ADDR_CTRL, 8'h04);
    repeat (20) @(posedge ref_clk_in);
    wr_reg(TMR2_ADDR_CTRL, 8'h00);
    rd_reg(TMR2_ADDR_CNTH, v);
    chk(v, 8'h13);
    rd_reg(TMR2_ADDR_CTRL, v);
    chk(v, 8'h00);
    // System clock divided by 12
    @(posedge ref_clk_in);
    lcs <= 1'b0;
    wr_reg(TMR2_ADDR_CNTL, 8'h00);
    wr_reg(TMR2_ADDR_CTRL, 8'h08);
    repeat (120) @(posedge ref_clk_in);
    wr_reg(TMR2_ADDR_CTRL, 8'h00);
    rd_reg(TMR2_ADDR_CNTL, v);
    chk_rng(v, 8'h09, 8'h0B);
    // External oscillator divided by 8
    wr_reg(TMR2_ADDR_CNTL, 8'h00);
    osc_en <= 1'b1;
    wr_reg(TMR2_ADDR_CTRL, 8'h09);
    repeat (800) @(posedge ref_clk_in);
    wr_reg(TMR2_ADDR_CTRL, 8'h00);
    osc_en <= 1'b0;
    rd_reg(TMR2_ADDR_CNTL, v);
    chk_rng(v, 8'h09, 8'h0B);
    // Capture on start-of-frame rising edge
    @(posedge ref_clk_in);
    lcs <= 1'b1;
    wr_reg(TMR2_ADDR_CNTH, 8'h34);
    wr_reg(TMR2_ADDR_CNTL, 8'h10);
    wr_reg(TMR2_ADDR_CTRL, 8'h14);
    repeat (10) @(posedge ref_clk_in);
    sof <= 1'b1;
    repeat (10) @(posedge ref_clk_in);
    wr_reg(TMR2_ADDR_CTRL, 8'h00);
    rd_reg(TMR2_ADDR_RLH, v);
    chk(v, 8'h34);
    rd_reg(TMR2_ADDR_RLL, v);
    chk_rng(v, 8'h14, 8'h24);
    // Capture on low-frequency oscillator falling edge
    sof <= 1'b0;
    wr_reg(TMR2_ADDR_CNTL, 8'h40);
    wr_reg(TMR2_ADDR_CTRL, 8'h16);
    repeat (10) @(posedge ref_clk_in);
    lfo <= 1'b0;
    repeat (10) @(posedge ref_clk_in);
    wr_reg(TMR2_ADDR_CTRL, 8'h00);
    rd_reg(TMR2_ADDR_RLL, v);
    chk_rng(v, 8'h44, 8'h54);
    report_and_stop();
  end
endmodule : timer2_reload_capture_regs_bench
